// *** gtp_pkg.sv ***
// Shared types and constants of the gated/triggered pulse modulator
`default_nettype none
package gtp_pkg;
	// System clock and internal timebase
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_NS = 20;
	localparam int TICK_DIV = TICK_NS / CLK_PERIOD_NS;
	localparam logic [7:0] TICK_DIV_LAST = 8'(TICK_DIV - 1);
	// Sync marker must stay high for more than 75 ns
	localparam int SYNC_MIN_NS = 75;
	localparam int SYNC_W_NS = 80;
	localparam int SYNC_W_CYC = (SYNC_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [31:0] SYNC_W_CYC_V = 32'(SYNC_W_CYC);
	// Envelope monitor leads the switch drive by a typical 50 ns
	localparam int ENV_LEAD_NS = 50;
	localparam int ENV_LEAD_CYC = ENV_LEAD_NS / CLK_PERIOD_NS;
	// Values after reset, in ns, then in timebase ticks
	localparam longint RST_INTERVAL_NS = 1000000000;
	localparam longint RST_WIDTH_NS = 10000000;
	localparam longint RST_SYNC_DLY_NS = 10000000;
	localparam longint RST_TRIG_DLY_NS = 1000000000;
	localparam logic [31:0] RST_INTERVAL_TK = 32'(RST_INTERVAL_NS / TICK_NS);
	localparam logic [31:0] RST_WIDTH_TK = 32'(RST_WIDTH_NS / TICK_NS);
	localparam logic [31:0] RST_SYNC_DLY_TK = 32'(RST_SYNC_DLY_NS / TICK_NS);
	localparam logic [31:0] RST_TRIG_DLY_TK = 32'(RST_TRIG_DLY_NS / TICK_NS);

	typedef enum logic {GTP_GATED, GTP_TRIGGERED} gtp_mode_e;

	// Modulator setup; all times in timebase ticks
	typedef struct packed {
		logic pulse_modulation_on;
		gtp_mode_e mode;
		logic gate_active_low;
		logic trig_falling;
		logic [31:0] repetition_interval;
		logic [31:0] width;
		logic [31:0] sync_delay;
		logic [31:0] trigger_to_pulse_delay;
	} gtp_cfg_s;

	// Observable outputs
	typedef struct packed {
		logic envelope_monitor;
		logic rf_switch_drive;
		logic sync_marker_output;
		logic rf_output_enable_indicator;
	} gtp_out_s;
endpackage
`default_nettype wire

// *** gtp_insync.sv ***
// Three-stage synchroniser for an asynchronous pin
`default_nettype none
module gtp_insync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Pin and clean level
	input wire logic pin,
	output logic level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// First stage feeds only the second
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	assign level = level_r;
endmodule
`default_nettype wire

// *** gtp_pulse_timer.sv ***
// One-shot: wait a delay in ticks, then hold a pulse for a width
`default_nettype none
module gtp_pulse_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Count enables
	input wire logic delay_en,
	input wire logic width_en,
	// Control
	input wire logic clr,
	input wire logic start,
	input wire logic [31:0] delay,
	input wire logic [31:0] width,
	// Status
	output logic busy,
	output logic pulse
);
	typedef enum logic [1:0] {GTP_IDLE, GTP_WAIT, GTP_HIGH} gtp_tmr_e;
	gtp_tmr_e state_r;
	logic [31:0] cnt_r;

	// Starts while busy are ignored; clr aborts at once
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= GTP_IDLE;
			cnt_r <= 32'h0;
		end else if (clr) begin
			state_r <= GTP_IDLE;
			cnt_r <= 32'h0;
		end else begin
			unique case (state_r)
				GTP_IDLE: begin
					if (start && delay == 32'h0) begin
						state_r <= GTP_HIGH;
						cnt_r <= width;
					end else if (start) begin
						state_r <= GTP_WAIT;
						cnt_r <= delay;
					end
				end
				GTP_WAIT: begin
					if (delay_en && cnt_r <= 32'h1) begin
						state_r <= GTP_HIGH;
						cnt_r <= width;
					end else if (delay_en) begin
						cnt_r <= cnt_r - 32'h1;
					end
				end
				GTP_HIGH: begin
					// A zero width still yields one count of pulse
					if (width_en && cnt_r <= 32'h1) begin
						state_r <= GTP_IDLE;
					end else if (width_en) begin
						cnt_r <= cnt_r - 32'h1;
					end
				end
				default: begin
					state_r <= GTP_IDLE;
				end
			endcase
		end
	end

	assign busy = (state_r != GTP_IDLE);
	assign pulse = (state_r == GTP_HIGH);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	chk_delay_holds: assert property (
		(!busy && start && !clr && delay != 32'h0) |=> !pulse ##0 busy)
		else $error("pulse began before its delay");
	chk_width_steady: assert property (
		(pulse && !width_en && !clr) |=> pulse)
		else $error("pulse ended without a count");
endmodule
`default_nettype wire

// *** gtp_modulator.sv ***
// Gated and triggered internal pulse modulation generator
// Functional notes
// - Gated: a pulse reaches the RF switch only if the gate passes at its leading edge.
// - Gated: a sync marker follows every internal pulse, gated through or not.
// - Gated: sync marker is over 75 ns and starts the sync delay after the pulse edge.
// - Envelope monitor follows the envelope and leads the switch drive by 50 ns (here 12 cycles, 48 ns).
// - Gate polarity selects high or low as the pass level.
// - Gated: the generator runs free at the repetition interval with set width.
// - Triggered: each valid edge gives one pulse of set width after the set delay.
// - Trigger edge setting picks rising or falling transitions only.
// - Triggered: sync marker over 75 ns starts sync delay after envelope rise.
// - RF passes only while output enable is set; an indicator shows it.
// - Gated setup resets to off, 1 s interval, 10 ms width and sync delay, high.
// - Triggered setup resets to off, 1 s delay, 10 ms width and sync, rising.
`default_nettype none
module gtp_modulator import gtp_pkg::*; #(
	parameter logic [31:0] RST_INTERVAL = RST_INTERVAL_TK,
	parameter logic [31:0] RST_WIDTH = RST_WIDTH_TK,
	parameter logic [31:0] RST_SYNC_DLY = RST_SYNC_DLY_TK,
	parameter logic [31:0] RST_TRIG_DLY = RST_TRIG_DLY_TK
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Setup, taken on cfg_load, and the output enable, taken every clock
	input wire gtp_cfg_s cfg_in,
	input wire logic cfg_load,
	input wire logic rf_output_enable,
	// Outside pin
	input wire logic gate_trigger_input,
	// Results
	output gtp_out_s mod_out,
	output gtp_cfg_s cfg_active
);
	localparam int LEAD_D = ENV_LEAD_CYC;
	localparam logic [7:0] LEAD_CNT = 8'(ENV_LEAD_CYC);

	gtp_cfg_s cfg_r;
	logic rf_en_r;
	logic [7:0] div_r;
	logic tick_r;
	logic gate_lvl;
	logic gate_prev_r;
	logic gate_ok;
	logic trig_edge;
	logic gated_run;
	logic trig_run;
	logic [31:0] per_cnt_r;
	logic lead_r;
	logic [31:0] wcnt_r;
	logic pass_r;
	logic env_r;
	logic env_nxt;
	logic env_prev_r;
	logic env_rise;
	logic trig_busy;
	logic trig_pulse;
	logic sync_start;
	logic sync_busy;
	logic sync_pulse;
	logic sync_r;
	logic [LEAD_D-1:0] lead_sr_r;
	logic drive_r;
	logic [31:0] sync_len_r;
	logic [7:0] env_on_cnt_r;

	// Setup register; reset values fix both menus at once
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r.pulse_modulation_on <= 1'b0;
			cfg_r.mode <= GTP_GATED;
			cfg_r.gate_active_low <= 1'b0;
			cfg_r.trig_falling <= 1'b0;
			cfg_r.repetition_interval <= RST_INTERVAL;
			cfg_r.width <= RST_WIDTH;
			cfg_r.sync_delay <= RST_SYNC_DLY;
			cfg_r.trigger_to_pulse_delay <= RST_TRIG_DLY;
		end else if (cfg_load) begin
			cfg_r <= cfg_in;
		end
	end

	// Output enable level comes from logic on this clock
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rf_en_r <= 1'b0;
		end else begin
			rf_en_r <= rf_output_enable;
		end
	end

	// Timebase divider: one tick every TICK_DIV cycles
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			div_r <= 8'h0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == TICK_DIV_LAST);
			div_r <= (div_r == TICK_DIV_LAST) ? 8'h0 : div_r + 8'h1;
		end
	end

	// The pin is TTL from outside, so it is synchronised first
	gtp_insync u_gate_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin(gate_trigger_input),
		.level(gate_lvl)
	);

	// Previous clean level for edge detection
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			gate_prev_r <= 1'b0;
		end else begin
			gate_prev_r <= gate_lvl;
		end
	end

	// Pass level and valid edge follow the polarity settings
	assign gate_ok = gate_lvl ^ cfg_r.gate_active_low;
	assign trig_edge = cfg_r.trig_falling ?
		(gate_prev_r && !gate_lvl) : (!gate_prev_r && gate_lvl);
	assign gated_run = cfg_r.pulse_modulation_on && cfg_r.mode == GTP_GATED;
	assign trig_run = cfg_r.pulse_modulation_on &&
		cfg_r.mode == GTP_TRIGGERED;

	// Free-running repetition counter; a lead pulse marks each period start
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			per_cnt_r <= 32'h0;
			lead_r <= 1'b0;
		end else if (!gated_run) begin
			per_cnt_r <= 32'h0;
			lead_r <= 1'b0;
		end else begin
			// Raised with the tick itself, so the width counts whole ticks
			lead_r <= (div_r == TICK_DIV_LAST) && per_cnt_r == 32'h0;
			if (tick_r && per_cnt_r + 32'h1 >= cfg_r.repetition_interval) begin
				per_cnt_r <= 32'h0;
			end else if (tick_r) begin
				per_cnt_r <= per_cnt_r + 32'h1;
			end
		end
	end

	// Width counter and gate decision, both taken at the lead edge
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wcnt_r <= 32'h0;
			pass_r <= 1'b0;
		end else if (!gated_run) begin
			wcnt_r <= 32'h0;
			pass_r <= 1'b0;
		end else if (lead_r) begin
			wcnt_r <= cfg_r.width;
			pass_r <= gate_ok;
		end else if (tick_r && wcnt_r != 32'h0) begin
			wcnt_r <= wcnt_r - 32'h1;
		end
	end

	// Triggered one-shot; a mode change aborts it
	gtp_pulse_timer u_trig_tmr (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.delay_en(tick_r),
		.width_en(tick_r),
		.clr(!trig_run),
		.start(trig_run && trig_edge),
		.delay(cfg_r.trigger_to_pulse_delay),
		.width(cfg_r.width),
		.busy(trig_busy),
		.pulse(trig_pulse)
	);

	// Envelope: open when modulation is off, else the active mode's pulse
	always_comb begin
		if (!cfg_r.pulse_modulation_on) begin
			env_nxt = 1'b1;
		end else if (cfg_r.mode == GTP_GATED) begin
			env_nxt = pass_r && wcnt_r != 32'h0;
		end else begin
			env_nxt = trig_pulse;
		end
	end

	// Envelope monitor register and its previous value
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			env_r <= 1'b0;
			env_prev_r <= 1'b0;
		end else begin
			env_r <= env_nxt;
			env_prev_r <= env_r;
		end
	end

	assign env_rise = env_r && !env_prev_r;

	// Sync marker source: every internal lead, or the envelope rise
	assign sync_start = gated_run ? lead_r : (trig_run && env_rise);

	// Sync marker one-shot; a new start while busy is dropped
	gtp_pulse_timer u_sync_tmr (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.delay_en(tick_r),
		.width_en(1'b1),
		.clr(!cfg_r.pulse_modulation_on),
		.start(sync_start),
		.delay(cfg_r.sync_delay),
		.width(SYNC_W_CYC_V),
		.busy(sync_busy),
		.pulse(sync_pulse)
	);

	// Switch drive lags the monitor so the monitor leads the RF pulse
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lead_sr_r <= '0;
			drive_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			lead_sr_r <= {lead_sr_r[LEAD_D-2:0], env_r};
			drive_r <= lead_sr_r[LEAD_D-2] && rf_en_r;
			sync_r <= sync_pulse;
		end
	end

	// Output bundle
	assign mod_out.envelope_monitor = env_r && rf_en_r;
	assign mod_out.rf_switch_drive = drive_r;
	assign mod_out.sync_marker_output = sync_r;
	assign mod_out.rf_output_enable_indicator = rf_en_r;
	assign cfg_active = cfg_r;

	// Length of the current sync marker, for checking only
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sync_len_r <= 32'h0;
		end else if (sync_r) begin
			sync_len_r <= sync_len_r + 32'h1;
		end else begin
			sync_len_r <= 32'h0;
		end
	end

	// Cycles the monitor has stood high with output enabled, for checking
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			env_on_cnt_r <= 8'h0;
		end else if (!(env_r && rf_en_r)) begin
			env_on_cnt_r <= 8'h0;
		end else if (env_on_cnt_r != 8'hff) begin
			env_on_cnt_r <= env_on_cnt_r + 8'h1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_lead_blocked;
		gated_run && lead_r && !gate_ok ##1 gated_run;
	endsequence

	sequence s_lead_passed;
		gated_run && lead_r && gate_ok && cfg_r.width != 32'h0 ##1 gated_run;
	endsequence

	chk_gate_blocks: assert property (
		s_lead_blocked |=> !env_r)
		else $error("blocked pulse reached envelope");
	chk_gate_passes: assert property (
		s_lead_passed |=> env_r)
		else $error("passed pulse missing from envelope");
	chk_sync_every: assert property (
		(gated_run && lead_r) |=> sync_busy)
		else $error("no sync marker after internal pulse");
	chk_sync_width: assert property (
		$fell(sync_r) |-> $past(sync_len_r) * CLK_PERIOD_NS > SYNC_MIN_NS)
		else $error("sync marker too short");
	chk_env_lead: assert property (
		(env_r && rf_en_r && env_on_cnt_r >= LEAD_CNT) |-> drive_r)
		else $error("switch drive not after monitor lead");
	chk_rf_gated: assert property (
		!$past(rf_en_r) |-> !drive_r)
		else $error("drive while output disabled");
	chk_off_open: assert property (
		(!cfg_r.pulse_modulation_on && !$past(cfg_load)) |=> env_r)
		else $error("envelope closed with modulation off");
	chk_trig_start: assert property (
		(trig_run && trig_edge && !trig_busy) |=> trig_busy)
		else $error("valid edge did not start pulse");
	chk_mode_one: assert property (
		!trig_run |=> !trig_pulse)
		else $error("triggered pulse outside triggered mode");
	chk_trig_sync: assert property (
		(trig_run && env_rise && !sync_busy) |=> sync_busy)
		else $error("no sync marker after envelope rise");
endmodule
`default_nettype wire

// *** gtp_ttl_src.sv ***
// Model of the outside TTL source on the shared gate or trigger pin
`default_nettype none
module gtp_ttl_src (
	// Clock
	input wire logic sys_clk,
	// Shared gate or trigger pin
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// A TTL source always drives a full level, never leaves the pin open
	initial pin = 1'b0;
	// New level just after an edge; the level doubles as gate or edge
	task automatic level(input logic v);
		@(posedge sys_clk);
		pin <= v;
	endtask
endmodule
`default_nettype wire

// *** gtp_modulator_tb.sv ***
// Self-checking bench of the gated and triggered pulse modulator
`default_nettype none
module gtp_modulator_tb import gtp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CW = $bits(gtp_cfg_s);
	logic sys_clk;
	logic resetn;
	logic cfg_load;
	logic rf_output_enable;
	gtp_cfg_s cfg_in;
	gtp_cfg_s rst_cfg;
	wire logic gate_trigger_input;
	gtp_out_s mod_out;
	gtp_cfg_s cfg_active;
	int mismatches = 0;
	int cmp_count = 0;
	int n_env, t_env0, t_env1, hi_env, n_syn, t_syn0, hi_syn, n_drv, t_drv0;

	// Real reset counts: modulation starts off, so they never have to run
	gtp_modulator gtp_modulator_i (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.cfg_in(cfg_in),
		.cfg_load(cfg_load),
		.rf_output_enable(rf_output_enable),
		.gate_trigger_input(gate_trigger_input),
		.mod_out(mod_out),
		.cfg_active(cfg_active)
	);
	gtp_ttl_src gtp_ttl_src_i (.sys_clk(sys_clk), .pin(gate_trigger_input));

	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Compare and count
	task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Timing slack: tick alignment and pin synchroniser latency
	function automatic logic near(input int d, input int e);
		return d >= e - 5 && d <= e + 5;
	endfunction

	task automatic results();
		$display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic load(input logic on, input gtp_mode_e m, input logic pol,
		input logic edg, input logic [31:0] iv, input logic [31:0] wd,
		input logic [31:0] sd, input logic [31:0] td);
		@(posedge sys_clk);
		cfg_in <= '{on, m, pol, edg, iv, wd, sd, td};
		cfg_load <= 1'b1;
		@(posedge sys_clk);
		cfg_load <= 1'b0;
		#1;
		check(cfg_active, cfg_in);
	endtask

	// Watch n cycles; rises are counted, widths taken of the first pulse only
	task automatic watch(input int n);
		logic pe;
		logic ps;
		logic pd;
		pe = mod_out.envelope_monitor;
		ps = mod_out.sync_marker_output;
		pd = mod_out.rf_switch_drive;
		{n_env, hi_env, n_syn, hi_syn, n_drv} = '0;
		{t_env0, t_env1, t_syn0, t_drv0} = {4{-32'sd1}};
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			#1;
			if (mod_out.envelope_monitor === 1'b1 && pe !== 1'b1) begin
				if (n_env == 0) t_env0 = i;
				else if (n_env == 1) t_env1 = i;
				n_env++;
			end
			if (mod_out.sync_marker_output === 1'b1 && ps !== 1'b1) begin
				n_syn++;
				if (t_env0 >= 0 && t_syn0 < 0) t_syn0 = i;
			end
			if (mod_out.rf_switch_drive === 1'b1 && pd !== 1'b1) begin
				n_drv++;
				if (t_env0 >= 0 && t_drv0 < 0) t_drv0 = i;
			end
			if (mod_out.envelope_monitor === 1'b1 && n_env == 1) hi_env++;
			if (mod_out.sync_marker_output === 1'b1 && n_syn == 1) hi_syn++;
			pe = mod_out.envelope_monitor;
			ps = mod_out.sync_marker_output;
			pd = mod_out.rf_switch_drive;
		end
	endtask

	// Hang guard, far above the two thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		results();
	end

	// Main sequence
	initial begin
		resetn = 1'b0;
		cfg_load = 1'b0;
		rf_output_enable = 1'b0;
		cfg_in = '0;
		rst_cfg = '{1'b0, GTP_GATED, 1'b0, 1'b0, RST_INTERVAL_TK, RST_WIDTH_TK,
			RST_SYNC_DLY_TK, RST_TRIG_DLY_TK};
		repeat (5) @(posedge sys_clk);
		check(CW'(mod_out), CW'(0));
		check(cfg_active, rst_cfg);
		resetn <= 1'b1;
		rf_output_enable <= 1'b1;
		gtp_ttl_src_i.level(1'b1);
		repeat (20) @(posedge sys_clk);
		#1;
		check(CW'(mod_out.rf_switch_drive), CW'(1));
		check(CW'(mod_out.rf_output_enable_indicator), CW'(1));
		// Gated, gate passing: interval 20 ticks, width 4, sync delay 2
		load(1'b1, GTP_GATED, 1'b0, 1'b0, 32'h14, 32'h4, 32'h2, 32'h6);
		repeat (30) @(posedge sys_clk);
		watch(300);
		check(CW'(t_env1 - t_env0), CW'(20 * TICK_DIV));
		check(CW'(hi_env), CW'(4 * TICK_DIV));
		check(CW'(t_drv0 - t_env0), CW'(ENV_LEAD_CYC));
		check(CW'(near(t_syn0 - t_env0, 2 * TICK_DIV)), CW'(1));
		check(CW'(hi_syn * CLK_PERIOD_NS > SYNC_MIN_NS), CW'(1));
		// Gate blocking: no RF pulses, sync markers go on
		gtp_ttl_src_i.level(1'b0);
		repeat (8) @(posedge sys_clk);
		watch(300);
		check(CW'(n_env), CW'(0));
		check(CW'(n_syn >= 2), CW'(1));
		// Same low level passes once the gate is active low; 16 ticks, width 3
		load(1'b1, GTP_GATED, 1'b1, 1'b0, 32'h10, 32'h3, 32'h2, 32'h6);
		watch(300);
		check(CW'(n_env >= 2), CW'(1));
		check(CW'(t_env1 - t_env0), CW'(16 * TICK_DIV));
		check(CW'(hi_env), CW'(3 * TICK_DIV));
		// Output disabled: nothing reaches the switch or monitor
		@(posedge sys_clk);
		rf_output_enable <= 1'b0;
		// Let the registered enable settle before rises are counted
		repeat (2) @(posedge sys_clk);
		watch(300);
		check(CW'(n_env + n_drv), CW'(0));
		check(CW'(mod_out.rf_output_enable_indicator), CW'(0));
		@(posedge sys_clk);
		rf_output_enable <= 1'b1;
		// Triggered on rising edges: delay 6 ticks, width 4, sync delay 3
		load(1'b1, GTP_TRIGGERED, 1'b0, 1'b0, 32'h14, 32'h4, 32'h3, 32'h6);
		repeat (30) @(posedge sys_clk);
		gtp_ttl_src_i.level(1'b1);
		watch(150);
		check(CW'(n_env), CW'(1));
		check(CW'(hi_env), CW'(4 * TICK_DIV));
		check(CW'(near(t_env0, 6 * TICK_DIV + 4)), CW'(1));
		check(CW'(near(t_syn0 - t_env0, 3 * TICK_DIV)), CW'(1));
		check(CW'(hi_syn * CLK_PERIOD_NS > SYNC_MIN_NS), CW'(1));
		gtp_ttl_src_i.level(1'b0);
		watch(150);
		check(CW'(n_env), CW'(0));
		// Falling-edge setting: only the high-to-low edge fires; delay 9, width 2
		load(1'b1, GTP_TRIGGERED, 1'b0, 1'b1, 32'h14, 32'h2, 32'h3, 32'h9);
		gtp_ttl_src_i.level(1'b1);
		watch(150);
		check(CW'(n_env), CW'(0));
		gtp_ttl_src_i.level(1'b0);
		watch(150);
		check(CW'(n_env), CW'(1));
		check(CW'(hi_env), CW'(2 * TICK_DIV));
		check(CW'(near(t_env0, 9 * TICK_DIV + 4)), CW'(1));
		// Modulation off again: switch held on
		load(1'b0, GTP_TRIGGERED, 1'b0, 1'b1, 32'h14, 32'h2, 32'h3, 32'h9);
		repeat (30) @(posedge sys_clk);
		#1;
		check(CW'(mod_out.rf_switch_drive), CW'(1));
		results();
	end
endmodule
`default_nettype wire
